//--- src/mwd_defines.svh
// Constants of the margin and watchdog command decoder
`ifndef MWD_DEFINES_SVH
`define MWD_DEFINES_SVH
// -----------------------------------------------------------------------------
// Slave address
// -----------------------------------------------------------------------------
`define MWD_ADDR_FIXED 5'h1D
// -----------------------------------------------------------------------------
// Command byte fields
// -----------------------------------------------------------------------------
`define MWD_OP_MARGIN 3'h1
`define MWD_OP_WDOG 3'h3
`define MWD_ARM_VAL 5'h00
`define MWD_MARGIN_BAD 4'hF
`define MWD_MARGIN_RST 4'h0
`define MWD_WD_PER_RST 2'h0
`define MWD_BIT_CNT 4'h8
// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define MWD_CLK_HZ 10000000
`define MWD_WD0_MS 1280
`define MWD_WD1_MS 320
`define MWD_WD2_MS 80
`define MWD_WD3_MS 20
`endif

//--- src/mwd_pkg.sv
// Types of the margin and watchdog command decoder
package mwd_pkg;
   typedef struct packed {
      logic [2:0] op;
      logic [4:0] val;
   } mwd_cmd_t;

   typedef struct packed {
      logic window;
      logic [1:0] period;
   } mwd_wdcfg_t;

   typedef struct packed {
      logic [3:0] ldo;
      logic [3:0] sw;
   } mwd_margin_t;

   typedef enum logic [2:0] {L_IDLE, L_ADDR, L_DATA, L_ACK, L_IGNORE} mwd_link_st_t;
   typedef enum logic [1:0] {D_IDLE, D_MARG1, D_MARG2, D_WDOG} mwd_dec_st_t;
endpackage

//--- src/mwd_cmd_decoder.sv
// Write-only margining and watchdog command decoder behind a two-wire slave
// What this block does
// R01 - Every data byte of a write transfer after the address is decoded in turn.
// R02 - Byte splits into 3-bit operation and 5-bit value; 001 margin, 011 watchdog.
// R03 - Operation code with all-zero value is an arming byte, except 001 00000 while margin is armed, which is a linear setting.
// R04 - Each operation starts with its arming byte; next byte sets that operation.
// R05 - Margin setting bit 4 picks linear (0) or switching (1) output.
// R06 - Low four bits: 0 nominal, 1-7 raise 1-7%, 8-14 lower 1-7%.
// R07 - Two margin settings after one arming byte set both outputs.
// R08 - Watchdog setting valid with bit 4 clear and bit 3 set; bit 2 window mode, bits 1:0 period.
// R09 - A valid watchdog setting after its arming byte starts the timer.
// R10 - Later watchdog settings clear the timer only while the window is open.
// R11 - An accepted watchdog setting clears timer and loads period and mode.
// R12 - Watchdog arming byte twice in a row stops and disables the watchdog.
// R13 - After disable, a valid watchdog setting restarts the timer.
// R14 - The master services the watchdog periodically with arming plus setting.
// R15 - On STOP the decoder returns to idle and waits for START.
// R16 - Address is five fixed bits plus clock-select and address-select pins.
// R17 - Slave receiver only: address with write bit and each byte acknowledged.
// R18 - Setting bytes without arming, or undefined operations, change nothing.
`include "mwd_defines.svh"

module mwd_cmd_decoder
   import mwd_pkg::*;
#(
   parameter int unsigned WD_CYC0 = `MWD_WD0_MS * (`MWD_CLK_HZ / 1000),
   parameter int unsigned WD_CYC1 = `MWD_WD1_MS * (`MWD_CLK_HZ / 1000),
   parameter int unsigned WD_CYC2 = `MWD_WD2_MS * (`MWD_CLK_HZ / 1000),
   parameter int unsigned WD_CYC3 = `MWD_WD3_MS * (`MWD_CLK_HZ / 1000),
   parameter int CNT_W = 24
) (
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic LINK_CLK,
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   input wire logic CLOCK_SELECT_PIN,
   input wire logic ADDR_SELECT_PIN,
   output mwd_margin_t MARGIN,
   output logic WDOG_ENABLE,
   output mwd_wdcfg_t WDOG_CFG,
   output logic WDOG_WINDOW_OPEN,
   output logic WDOG_EXPIRED
);
   // -----------------------------------------------------------------------------
   // Link domain reset and pin synchronisers
   // -----------------------------------------------------------------------------
   logic [1:0] lrst_q;
   logic link_rst;
   logic scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
   logic [1:0] pin_s1_q, pin_s2_q;

   // Asserted at once, released on the link clock
   always_ff @(posedge LINK_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         lrst_q <= 2'h3;
      end else begin
         lrst_q <= {lrst_q[0], 1'b0};
      end
   end
   assign link_rst = lrst_q[1];

   always_ff @(posedge LINK_CLK or posedge link_rst) begin
      if (link_rst) begin
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         scl_s3_q <= 1'b1;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
         sda_s3_q <= 1'b1;
         pin_s1_q <= 2'h3;
         pin_s2_q <= 2'h3;
      end else begin
         scl_s1_q <= SCL_IN;
         scl_s2_q <= scl_s1_q;
         scl_s3_q <= scl_s2_q;
         sda_s1_q <= SDA_IN;
         sda_s2_q <= sda_s1_q;
         sda_s3_q <= sda_s2_q;
         pin_s1_q <= {CLOCK_SELECT_PIN, ADDR_SELECT_PIN};
         pin_s2_q <= pin_s1_q;
      end
   end

   // -----------------------------------------------------------------------------
   // Link bit engine
   // -----------------------------------------------------------------------------
   logic start_det, stop_det, scl_rise, scl_fall, addr_hit, byte_done;
   mwd_link_st_t lst_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q, byte_q;
   logic ack_q, btog_q, stog_q;

   assign start_det = scl_s2_q && sda_s3_q && !sda_s2_q;
   assign stop_det = scl_s2_q && !sda_s3_q && sda_s2_q;
   assign scl_rise = scl_s2_q && !scl_s3_q;
   assign scl_fall = !scl_s2_q && scl_s3_q;
   assign addr_hit = (sh_q[7:1] == {`MWD_ADDR_FIXED, pin_s2_q}); // R16
   assign byte_done = scl_fall && (cnt_q == `MWD_BIT_CNT) && !start_det && !stop_det;

   always_ff @(posedge LINK_CLK or posedge link_rst) begin
      if (link_rst) begin
         lst_q <= L_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         ack_q <= 1'b0;
      end else if (start_det) begin
         lst_q <= L_ADDR;
         cnt_q <= 4'h0;
         ack_q <= 1'b0;
      end else if (stop_det) begin
         lst_q <= L_IDLE; // R15
         ack_q <= 1'b0;
      end else begin
         case (lst_q)
            L_ADDR, L_DATA: begin
               if (scl_rise) begin
                  sh_q <= {sh_q[6:0], sda_s2_q};
                  cnt_q <= cnt_q + 4'h1;
               end else if (byte_done) begin
                  // Reads are refused: the bus sees no acknowledge
                  if (lst_q == L_DATA || (addr_hit && !sh_q[0])) begin
                     ack_q <= 1'b1; // R17
                     lst_q <= L_ACK;
                  end else begin
                     lst_q <= L_IGNORE;
                  end
               end
            end
            L_ACK: begin
               if (scl_fall) begin
                  ack_q <= 1'b0;
                  cnt_q <= 4'h0;
                  lst_q <= L_DATA; // R01
               end
            end
            L_IDLE, L_IGNORE: begin
               lst_q <= lst_q;
            end
            default: begin
               lst_q <= L_IDLE;
            end
         endcase
      end
   end

   // Byte and stop events leave the link domain as toggles; byte_q stays
   // stable for a whole byte time, far longer than the crossing takes
   always_ff @(posedge LINK_CLK or posedge link_rst) begin
      if (link_rst) begin
         byte_q <= 8'h00;
         btog_q <= 1'b0;
         stog_q <= 1'b0;
      end else begin
         if (lst_q == L_DATA && byte_done) begin
            byte_q <= sh_q; // R01
            btog_q <= ~btog_q;
         end
         if (stop_det && !start_det) begin
            stog_q <= ~stog_q;
         end
      end
   end

   assign SDA_OUT = 1'b0;
   assign SDA_OE = ack_q;

   // -----------------------------------------------------------------------------
   // Event crossing into the system clock
   // -----------------------------------------------------------------------------
   logic [2:0] bs_q, ss_q;
   logic evt, stop_evt;
   mwd_cmd_t cmd;

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         bs_q <= 3'h0;
         ss_q <= 3'h0;
      end else begin
         bs_q <= {bs_q[1:0], btog_q};
         ss_q <= {ss_q[1:0], stog_q};
      end
   end
   assign evt = bs_q[2] ^ bs_q[1];
   assign stop_evt = ss_q[2] ^ ss_q[1];
   assign cmd = mwd_cmd_t'(byte_q); // R02

   // -----------------------------------------------------------------------------
   // Command decoder
   // -----------------------------------------------------------------------------
   mwd_dec_st_t dst_q;
   logic is_arm_m, is_arm_w, m_take, w_valid, w_take, w_off;

   assign is_arm_m = (cmd.op == `MWD_OP_MARGIN) && (cmd.val == `MWD_ARM_VAL); // R03
   assign is_arm_w = (cmd.op == `MWD_OP_WDOG) && (cmd.val == `MWD_ARM_VAL); // R03
   // After a margin arm, 001 00000 is the linear output's nominal setting
   assign m_take = evt && (dst_q == D_MARG1 || dst_q == D_MARG2) && (cmd.op == `MWD_OP_MARGIN)
                   && (cmd.val[3:0] != `MWD_MARGIN_BAD); // R04 R06
   assign w_valid = (cmd.op == `MWD_OP_WDOG) && !cmd.val[4] && cmd.val[3]; // R08
   assign w_take = evt && (dst_q == D_WDOG) && w_valid; // R04
   assign w_off = evt && (dst_q == D_WDOG) && is_arm_w; // R12

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         dst_q <= D_IDLE;
      end else if (stop_evt) begin
         dst_q <= D_IDLE; // R15
      end else if (evt) begin
         case (dst_q)
            D_MARG1: begin
               dst_q <= m_take ? D_MARG2 : (is_arm_w ? D_WDOG : D_IDLE); // R07
            end
            D_MARG2: begin
               dst_q <= (!m_take && is_arm_w) ? D_WDOG : D_IDLE;
            end
            D_WDOG: begin
               dst_q <= (is_arm_m && !w_off) ? D_MARG1 : D_IDLE;
            end
            D_IDLE: begin
               // Anything but an arming byte is dropped here
               dst_q <= is_arm_m ? D_MARG1 : (is_arm_w ? D_WDOG : D_IDLE); // R18
            end
            default: begin
               dst_q <= D_IDLE;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------------------
   // Margin settings
   // -----------------------------------------------------------------------------
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         MARGIN <= '{ldo: `MWD_MARGIN_RST, sw: `MWD_MARGIN_RST};
      end else if (m_take) begin
         if (cmd.val[4]) begin
            MARGIN.sw <= cmd.val[3:0]; // R05
         end else begin
            MARGIN.ldo <= cmd.val[3:0]; // R05
         end
      end
   end

   // -----------------------------------------------------------------------------
   // Watchdog timer
   // -----------------------------------------------------------------------------
   logic [CNT_W-1:0] wd_cnt_q, wd_lim;
   logic win_open;

   always_comb begin
      case (WDOG_CFG.period)
         2'h0: wd_lim = CNT_W'(WD_CYC0);
         2'h1: wd_lim = CNT_W'(WD_CYC1);
         2'h2: wd_lim = CNT_W'(WD_CYC2);
         default: wd_lim = CNT_W'(WD_CYC3);
      endcase
   end
   // In window mode the timer may be cleared only in the second half
   assign win_open = !WDOG_CFG.window || (wd_cnt_q >= (wd_lim >> 1));
   assign WDOG_WINDOW_OPEN = WDOG_ENABLE && win_open;

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         WDOG_ENABLE <= 1'b0;
         WDOG_CFG <= '{window: 1'b0, period: `MWD_WD_PER_RST};
         wd_cnt_q <= '0;
         WDOG_EXPIRED <= 1'b0;
      end else if (w_off) begin
         WDOG_ENABLE <= 1'b0; // R12
         wd_cnt_q <= '0;
         WDOG_EXPIRED <= 1'b0;
      end else if (w_take && (!WDOG_ENABLE || win_open)) begin
         WDOG_ENABLE <= 1'b1; // R09 R13
         WDOG_CFG <= '{window: cmd.val[2], period: cmd.val[1:0]}; // R11
         wd_cnt_q <= '0; // R10
         WDOG_EXPIRED <= 1'b0;
      end else if (WDOG_ENABLE && !WDOG_EXPIRED) begin
         // Expiry freezes the count; what follows is left to the system
         if (wd_cnt_q == wd_lim - CNT_W'(1)) begin
            WDOG_EXPIRED <= 1'b1;
         end else begin
            wd_cnt_q <= wd_cnt_q + CNT_W'(1);
         end
      end
   end

   // -----------------------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------------------
   property p_addr_ack;
      @(posedge LINK_CLK) disable iff (link_rst)
      (lst_q == L_ADDR && byte_done && addr_hit && !sh_q[0]) |=> SDA_OE && lst_q == L_ACK;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged"); // R16

   property p_read_nack;
      @(posedge LINK_CLK) disable iff (link_rst)
      (lst_q == L_ADDR && byte_done && sh_q[0]) |=> !SDA_OE && lst_q == L_IGNORE;
   endproperty
   a_read_nack: assert property (p_read_nack) else $error("read request acknowledged"); // R17

   property p_byte_fwd;
      @(posedge LINK_CLK) disable iff (link_rst)
      (lst_q == L_DATA && byte_done) |=> $changed(btog_q) && byte_q == $past(sh_q) && SDA_OE;
   endproperty
   a_byte_fwd: assert property (p_byte_fwd) else $error("data byte not forwarded"); // R01

   property p_stop_idle;
      @(posedge LINK_CLK) disable iff (link_rst)
      (stop_det && !start_det) |=> lst_q == L_IDLE && !SDA_OE;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("link not idle after stop"); // R15

   sequence s_marg_arm;
      evt && !stop_evt && dst_q == D_IDLE && is_arm_m;
   endsequence
   sequence s_first_set;
      m_take && !stop_evt && dst_q == D_MARG1;
   endsequence

   property p_arm;
      @(posedge CLOCK) disable iff (SYS_RST)
      s_marg_arm |=> dst_q == D_MARG1 ##1 MARGIN == $past(MARGIN, 2);
   endproperty
   a_arm: assert property (p_arm) else $error("arming byte mishandled"); // R04

   property p_margin_pair;
      @(posedge CLOCK) disable iff (SYS_RST)
      s_first_set |=> dst_q == D_MARG2;
   endproperty
   a_margin_pair: assert property (p_margin_pair) else $error("second margin byte lost"); // R07

   property p_margin_ldo;
      @(posedge CLOCK) disable iff (SYS_RST)
      (m_take && !cmd.val[4]) |=> MARGIN.ldo == $past(cmd.val[3:0]) && $stable(MARGIN.sw);
   endproperty
   a_margin_ldo: assert property (p_margin_ldo) else $error("linear margin not applied"); // R06

   property p_ignore;
      @(posedge CLOCK) disable iff (SYS_RST)
      (evt && dst_q == D_IDLE) |=> $stable(MARGIN) && $stable(WDOG_CFG) && $stable(WDOG_ENABLE);
   endproperty
   a_ignore: assert property (p_ignore) else $error("unarmed byte changed a setting"); // R18

   property p_wd_start;
      @(posedge CLOCK) disable iff (SYS_RST)
      (w_take && !WDOG_ENABLE) |=> WDOG_ENABLE && wd_cnt_q == '0 ##1 wd_cnt_q == CNT_W'(1);
   endproperty
   a_wd_start: assert property (p_wd_start) else $error("watchdog not started"); // R09

   // A closed window implies the count is below half, so expiry cannot coincide
   property p_wd_closed;
      @(posedge CLOCK) disable iff (SYS_RST)
      (w_take && WDOG_ENABLE && !win_open) |=> wd_cnt_q == $past(wd_cnt_q) + CNT_W'(1);
   endproperty
   a_wd_closed: assert property (p_wd_closed) else $error("cleared in closed window"); // R10

   property p_wd_load;
      @(posedge CLOCK) disable iff (SYS_RST)
      (w_take && win_open) |=> wd_cnt_q == '0 && WDOG_CFG == $past(cmd.val[2:0]);
   endproperty
   a_wd_load: assert property (p_wd_load) else $error("watchdog setting not loaded"); // R11

   property p_wd_off;
      @(posedge CLOCK) disable iff (SYS_RST)
      w_off |=> !WDOG_ENABLE && dst_q == D_IDLE;
   endproperty
   a_wd_off: assert property (p_wd_off) else $error("watchdog not disabled"); // R12
endmodule

//--- test/mwd_bus_master.sv
// Two-wire bus master model that sends write transfers to the decoder
module mwd_bus_master (
   input wire logic clk,
   input wire logic sda_line,
   output logic scl,
   output logic sda
);
   timeunit 1ns;
   timeprecision 100ps;
   // -----------------------------------------------------------------------
   // Bus idles high through the pull-ups, clock stands still between frames
   // -----------------------------------------------------------------------
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // SCL and SDA never move on one edge, so no false START or STOP is seen
   task automatic step(input logic c, input logic d);
      @(posedge clk);
      scl <= c;
      sda <= d;
   endtask
   task automatic start();
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b1, 1'b0);
   endtask
   task automatic put_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         step(1'b0, sda);
         step(1'b0, b[i]);
         step(1'b1, b[i]);
         step(1'b1, b[i]);
      end
      step(1'b0, sda);
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b1);
      ack = ~sda_line;
   endtask
   task automatic stop();
      step(1'b0, sda);
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask
endmodule

//--- test/mwd_cmd_decoder_tb.sv
// Self-checking testbench of the margin and watchdog command decoder
module mwd_cmd_decoder_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 1'b0;
   logic link_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic scl, sda_m, sda_line, sda_out, sda_oe, wd_en, win, expd;
   logic cs_pin = 1'b1;
   logic as_pin = 1'b0;
   mwd_pkg::mwd_margin_t margin;
   mwd_pkg::mwd_wdcfg_t wd_cfg;
   int n_errors = 0;
   int comparisons = 0;
   int n;
   always #50 clock = ~clock;
   initial begin
      #1.7;
      forever #3 link_clk = ~link_clk;
   end
   // Open-drain data line with pull-up
   assign sda_line = sda_m & (sda_oe ? sda_out : 1'b1);
   mwd_bus_master u_master (.clk(clock), .sda_line(sda_line), .scl(scl), .sda(sda_m));
   mwd_cmd_decoder #(.WD_CYC0(6000), .WD_CYC1(3000), .WD_CYC2(2000), .WD_CYC3(1500)) u_dut (
      .CLOCK(clock), .SYS_RST(sys_rst), .LINK_CLK(link_clk), .SCL_IN(scl), .SDA_IN(sda_line),
      .SDA_OUT(sda_out), .SDA_OE(sda_oe), .CLOCK_SELECT_PIN(cs_pin), .ADDR_SELECT_PIN(as_pin),
      .MARGIN(margin), .WDOG_ENABLE(wd_en), .WDOG_CFG(wd_cfg), .WDOG_WINDOW_OPEN(win),
      .WDOG_EXPIRED(expd));
   // -----------------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------------
   task automatic results();
      if (n_errors == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Sends n bytes, first byte in the top of d
   task automatic xfer(input logic [6:0] a, input logic [31:0] d, input int n,
                       input logic exp_ack);
      logic ack;
      u_master.start();
      u_master.put_byte({a, 1'b0}, ack);
      check(ack, exp_ack);
      for (int i = 0; i < n; i++) begin
         u_master.put_byte(d[31 - 8 * i -: 8], ack);
         check(ack, exp_ack);
      end
      u_master.stop();
      repeat (6) @(posedge clock);
   endtask
   // Bounded wait on the window flag (sel 0) or the expiry flag (sel 1)
   task automatic wait_hi(input logic sel, input int lim, output int k);
      k = 0;
      while ((sel ? expd : win) !== 1'b1) begin
         @(posedge clock);
         k++;
         if (k == lim) begin
            n_errors++;
            $display("[FAIL] %0t ns: wait ran out", $time);
            results();
         end
      end
   endtask
   // -----------------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------------
   initial begin
      logic ack;
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (10) @(posedge clock);
      check(margin, 8'h00);
      check({wd_en, wd_cfg, win, expd}, 8'h00);
      xfer(7'h76, 32'h20253C00, 3, 1'b1);
      check(margin, 8'h5C);
      for (int v = 0; v < 15; v++) begin
         xfer(7'h76, {8'h20, 4'h3, v[3:0], 16'h0000}, 2, 1'b1);
         check(margin, {4'h5, v[3:0]});
      end
      // Code 1111 is refused and drops the arming, so the next byte is unarmed
      xfer(7'h76, 32'h203F2700, 3, 1'b1);
      check(margin, 8'h5E);
      xfer(7'h76, 32'h2B000000, 1, 1'b1);
      check(margin, 8'h5E);
      xfer(7'h76, 32'h20A52300, 3, 1'b1);
      check(margin, 8'h5E);
      xfer(7'h76, 32'h20213A33, 4, 1'b1);
      check(margin, 8'h1A);
      xfer(7'h76, 32'h20000000, 1, 1'b1);
      xfer(7'h76, 32'h23000000, 1, 1'b1);
      check(margin, 8'h1A);
      xfer(7'h77, 32'h20220000, 2, 1'b0);
      check(margin, 8'h1A);
      cs_pin <= 1'b0;
      as_pin <= 1'b1;
      repeat (4) @(posedge clock);
      xfer(7'h75, 32'h20240000, 2, 1'b1);
      check(margin, 8'h4A);
      u_master.start();
      u_master.put_byte(8'hEB, ack);
      check(ack, 1'b0);
      u_master.stop();
      // Every watchdog setting, each followed by a disable
      for (int c = 0; c < 8; c++) begin
         xfer(7'h75, {8'h60, 5'h0D, c[2:0], 16'h0000}, 2, 1'b1);
         check({wd_en, wd_cfg}, {5'h01, c[2:0]});
         xfer(7'h75, 32'h60600000, 2, 1'b1);
         check({wd_en, expd}, 8'h00);
      end
      xfer(7'h75, 32'h60646078, 4, 1'b1);
      check(wd_en, 1'b0);
      // Window mode: a service in the closed half is ignored
      xfer(7'h75, 32'h606C0000, 2, 1'b1);
      xfer(7'h75, 32'h606D0000, 2, 1'b1);
      check({wd_en, wd_cfg, win}, 8'h18);
      wait_hi(1'b0, 6000, n);
      check(n > 2500, 1'b1);
      xfer(7'h75, 32'h606D0000, 2, 1'b1);
      check({wd_en, wd_cfg, win}, 8'h1A);
      wait_hi(1'b1, 4000, n);
      check(n > 2800, 1'b1);
      xfer(7'h75, 32'h60600000, 2, 1'b1);
      check({wd_en, expd}, 8'h00);
      results();
   end
endmodule
